// ===== i2c_reg_pkg.sv
// constants shared by the two-wire register slave and its crc engine
// assumes a single 10 MHz core clock; bus pins are sampled, not used as clocks
package i2c_reg_pkg;

    // default bus address of the device, even member of the address pair
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h6C;

    // crc polynomials and seeds, msb first
    localparam logic [3:0] CRC4_POLY = 4'h3;
    localparam logic [3:0] CRC4_SEED = 4'hF;
    localparam logic [7:0] CRC8_POLY = 8'hD5;
    localparam logic [7:0] CRC8_SEED = 8'hFF;

    // received byte position
    localparam logic [1:0] IDX_SLAVE = 2'h0;
    localparam logic [1:0] IDX_MEMADDR = 2'h1;
    localparam logic [1:0] IDX_LEN = 2'h2;
    localparam logic [1:0] IDX_DATA = 2'h3;

    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] NIBBLE_BITS = 3'h4;
    localparam logic [2:0] CNT_MAX = 3'h7;
    // largest length code allowed in a protected frame (4 bytes)
    localparam logic [3:0] MAX_LEN_CODE = 4'h3;
    // byte sent once a protected read has run past its crc
    localparam logic [7:0] IDLE_BYTE = 8'hFF;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_ACK = 3'b010,
        ST_TX = 3'b011,
        ST_MACK = 3'b100
    } link_state_t;

endpackage

// ===== crc_bit_engine.sv
// bit-serial crc4 and crc8 accumulators, msb first
// assumes enables are single-cycle pulses from the same clock domain
`timescale 1ns/1ns
`default_nettype none

module crc_bit_engine
    import i2c_reg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic init,
    input wire logic en4,
    input wire logic en8,
    input wire logic bit_in,
    output logic [3:0] crc4,
    output logic [7:0] crc8
);

    logic [3:0] crc4_reg;
    logic [3:0] crc4_next;
    logic [7:0] crc8_reg;
    logic [7:0] crc8_next;

    // one shift step per enabled bit; init wins so a new frame starts clean
    always_comb
    begin
        crc4_next = crc4_reg;
        crc8_next = crc8_reg;
        if (init)
        begin
            crc4_next = CRC4_SEED;
            crc8_next = CRC8_SEED;
        end
        else
        begin
            if (en4)
            begin
                crc4_next = {crc4_reg[2:0], 1'b0} ^
                    ((bit_in ^ crc4_reg[3]) ? CRC4_POLY : 4'h0);
            end
            if (en8)
            begin
                crc8_next = {crc8_reg[6:0], 1'b0} ^
                    ((bit_in ^ crc8_reg[7]) ? CRC8_POLY : 8'h00);
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            crc4_reg <= CRC4_SEED;
            crc8_reg <= CRC8_SEED;
        end
        else
        begin
            crc4_reg <= crc4_next;
            crc8_reg <= crc8_next;
        end
    end

    assign crc4 = crc4_reg;
    assign crc8 = crc8_reg;

endmodule
`default_nettype wire

// ===== sensor_register_i2c_slave.sv
// two-wire slave giving a bus master access to 16-bit register memory
// assumes the memory answers mem_rdata combinationally for mem_addr
// Notes on behaviour
// - random write stores bytes at consecutive addresses
// - plain random read returns consecutive bytes until the master ends
// - read-last restarts from the last set address
// - 7-bit address; lowest bit picks frame type
// - bit 0 plain framing, 1 crc framing
// - answers on the even and odd address
// - plain and crc frames interleave
// - crc read-last repeats byte count, then crc8
// - low byte then high byte, msb first
// - crc4 poly 0x03 seed 0x0F; crc8 poly 0xD5 seed 0xFF
// - crc mismatch sets sticky fault flag
`timescale 1ns/1ns
`default_nettype none

module sensor_register_i2c_slave
    import i2c_reg_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic [7:0] mem_addr,
    output logic [15:0] mem_wdata,
    output logic mem_we,
    input wire logic [15:0] mem_rdata,
    output logic crc_fault,
    input wire logic crc_fault_clr
);

    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic scl_prev_reg;
    logic sda_prev_reg;
    logic [1:0] scl_sync_next;
    logic [1:0] sda_sync_next;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    link_state_t state_reg, state_next;
    logic [2:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [1:0] byte_idx_reg, byte_idx_next;
    logic done_reg, done_next;
    logic ack_reg, ack_next;
    logic rw_reg, rw_next;
    logic crc_mode_reg, crc_mode_next;
    logic [7:0] start_addr_reg, start_addr_next;
    logic [7:0] cur_addr_reg, cur_addr_next;
    logic [3:0] len_reg, len_next;
    logic [2:0] data_cnt_reg, data_cnt_next;
    logic [7:0] wlo_reg, wlo_next;
    logic [31:0] wbuf_reg, wbuf_next;
    logic [7:0] tx_shift_reg, tx_shift_next;
    logic tx_data_reg, tx_data_next;
    logic mack_ok_reg, mack_ok_next;
    logic [1:0] commit_left_reg, commit_left_next;
    logic commit_idx_reg, commit_idx_next;
    logic oe_n_reg, oe_n_next;
    logic [7:0] mem_addr_reg, mem_addr_next;
    logic [15:0] mem_wdata_reg, mem_wdata_next;
    logic mem_we_reg, mem_we_next;
    logic fault_reg, fault_next;

    logic crc_init;
    logic crc_en4;
    logic crc_en8;
    logic crc_bit;
    logic [3:0] crc4_val;
    logic [7:0] crc8_val;
    logic [7:0] rx_byte;
    logic [3:0] len_plus;
    logic [3:0] cnt4;
    logic load;
    logic fault_set;

    // pin synchronisers; stage 0 feeds only stage 1
    always_comb
    begin
        scl_sync_next = {scl_sync_reg[0], scl_in};
        sda_sync_next = {sda_sync_reg[0], sda_in};
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end
        else
        begin
            scl_sync_reg <= scl_sync_next;
            sda_sync_reg <= sda_sync_next;
            scl_prev_reg <= scl_sync_reg[1];
            sda_prev_reg <= sda_sync_reg[1];
        end
    end

    // bus events seen on the clean copies
    assign scl = scl_sync_reg[1];
    assign sda = sda_sync_reg[1];
    assign scl_rise = scl & ~scl_prev_reg;
    assign scl_fall = ~scl & scl_prev_reg;
    assign bus_start = scl & scl_prev_reg & sda_prev_reg & ~sda;
    assign bus_stop = scl & scl_prev_reg & ~sda_prev_reg & sda;
    assign rx_byte = {shift_reg[6:0], sda};
    assign len_plus = len_reg + 4'h1;
    assign cnt4 = {1'b0, data_cnt_reg};

    crc_bit_engine crc_unit (
        .clk(clk),
        .rst(rst),
        .init(crc_init),
        .en4(crc_en4),
        .en8(crc_en8),
        .bit_in(crc_bit),
        .crc4(crc4_val),
        .crc8(crc8_val)
    );

    // frame sequencer; own sda changes only on scl falls, so no false starts
    always_comb
    begin
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg;
        shift_next = shift_reg;
        byte_idx_next = byte_idx_reg;
        done_next = done_reg;
        ack_next = ack_reg;
        rw_next = rw_reg;
        crc_mode_next = crc_mode_reg;
        start_addr_next = start_addr_reg;
        cur_addr_next = cur_addr_reg;
        len_next = len_reg;
        data_cnt_next = data_cnt_reg;
        wlo_next = wlo_reg;
        wbuf_next = wbuf_reg;
        tx_shift_next = tx_shift_reg;
        tx_data_next = tx_data_reg;
        mack_ok_next = mack_ok_reg;
        commit_left_next = commit_left_reg;
        commit_idx_next = commit_idx_reg;
        oe_n_next = oe_n_reg;
        mem_addr_next = mem_addr_reg;
        mem_wdata_next = mem_wdata_reg;
        mem_we_next = 1'b0;
        crc_init = 1'b0;
        crc_en4 = 1'b0;
        crc_en8 = 1'b0;
        crc_bit = sda;
        load = 1'b0;
        fault_set = 1'b0;
        // checked crc words committed one per cycle
        if (commit_left_reg != 2'h0)
        begin
            mem_we_next = 1'b1;
            mem_addr_next = start_addr_reg + {6'h00, commit_idx_reg, 1'b0};
            mem_wdata_next = commit_idx_reg ? wbuf_reg[31:16] : wbuf_reg[15:0];
            commit_left_next = commit_left_reg - 2'h1;
            commit_idx_next = ~commit_idx_reg;
        end
        if (bus_start)
        begin
            // (repeated) start: each header picks its framing
            state_next = ST_RX;
            bit_cnt_next = 3'h0;
            byte_idx_next = IDX_SLAVE;
            done_next = 1'b0;
            oe_n_next = 1'b1;
            crc_init = 1'b1;
        end
        else if (bus_stop)
        begin
            state_next = ST_IDLE;
            oe_n_next = 1'b1;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                end
                ST_RX:
                begin
                    if (scl_rise && !done_reg)
                    begin
                        shift_next = rx_byte;
                        bit_cnt_next = bit_cnt_reg + 3'h1;
                        // crc4 covers header bits up to the length nibble
                        crc_en4 = (byte_idx_reg < IDX_LEN) ||
                            (byte_idx_reg == IDX_LEN && bit_cnt_reg < NIBBLE_BITS);
                        crc_en8 = byte_idx_reg == IDX_DATA && crc_mode_reg &&
                            cnt4 < len_plus;
                        if (bit_cnt_reg == LAST_BIT)
                        begin
                            done_next = 1'b1;
                            ack_next = 1'b1;
                            unique case (byte_idx_reg)
                                IDX_SLAVE:
                                begin
                                    // header bit 1 is frame type
                                    if (rx_byte[7:2] == DEV_ADDR[6:1])
                                    begin
                                        rw_next = rx_byte[0];
                                        crc_mode_next = rx_byte[1];
                                        byte_idx_next = IDX_MEMADDR;
                                        cur_addr_next = start_addr_reg;
                                        data_cnt_next = 3'h0;
                                    end
                                    else
                                    begin
                                        ack_next = 1'b0;
                                    end
                                end
                                IDX_MEMADDR:
                                begin
                                    start_addr_next = rx_byte;
                                    cur_addr_next = rx_byte;
                                    byte_idx_next = crc_mode_reg ? IDX_LEN : IDX_DATA;
                                end
                                IDX_LEN:
                                begin
                                    // longer frames refused
                                    if (crc4_val == rx_byte[3:0] &&
                                        rx_byte[7:4] <= MAX_LEN_CODE)
                                    begin
                                        len_next = rx_byte[7:4];
                                        byte_idx_next = IDX_DATA;
                                    end
                                    else
                                    begin
                                        fault_set = crc4_val != rx_byte[3:0];
                                        ack_next = 1'b0;
                                    end
                                end
                                IDX_DATA:
                                begin
                                    if (!crc_mode_reg)
                                    begin
                                        // low byte waits for high byte
                                        if (!cur_addr_reg[0])
                                        begin
                                            wlo_next = rx_byte;
                                        end
                                        else
                                        begin
                                            mem_we_next = 1'b1;
                                            mem_addr_next = {cur_addr_reg[7:1], 1'b0};
                                            mem_wdata_next = {rx_byte, wlo_reg};
                                        end
                                        cur_addr_next = cur_addr_reg + 8'h01;
                                    end
                                    else if (cnt4 < len_plus)
                                    begin
                                        // held until crc8 agrees
                                        wbuf_next[{data_cnt_reg[1:0], 3'b000} +: 8] = rx_byte;
                                        data_cnt_next = data_cnt_reg + 3'h1;
                                    end
                                    else if (cnt4 == len_plus && crc8_val == rx_byte)
                                    begin
                                        commit_left_next = len_reg[2:1] + {1'b0, len_reg[0]};
                                        commit_idx_next = 1'b0;
                                        data_cnt_next = data_cnt_reg + 3'h1;
                                    end
                                    else
                                    begin
                                        fault_set = cnt4 == len_plus;
                                        ack_next = 1'b0;
                                    end
                                end
                            endcase
                        end
                    end
                    else if (scl_fall && done_reg)
                    begin
                        done_next = 1'b0;
                        state_next = ack_reg ? ST_ACK : ST_IDLE;
                        oe_n_next = ~ack_reg;
                    end
                end
                ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        oe_n_next = 1'b1;
                        state_next = ST_RX;
                        load = rw_reg;
                    end
                end
                ST_TX:
                begin
                    if (scl_rise)
                    begin
                        crc_bit = tx_shift_reg[7];
                        crc_en8 = tx_data_reg;
                    end
                    else if (scl_fall)
                    begin
                        if (bit_cnt_reg == LAST_BIT)
                        begin
                            oe_n_next = 1'b1;
                            state_next = ST_MACK;
                            bit_cnt_next = 3'h0;
                        end
                        else
                        begin
                            tx_shift_next = {tx_shift_reg[6:0], 1'b0};
                            oe_n_next = tx_shift_reg[6];
                            bit_cnt_next = bit_cnt_reg + 3'h1;
                        end
                    end
                end
                ST_MACK:
                begin
                    if (scl_rise)
                    begin
                        mack_ok_next = ~sda;
                    end
                    else if (scl_fall)
                    begin
                        // a nack ends the read and leaves the line released
                        load = mack_ok_reg;
                        state_next = ST_IDLE;
                    end
                end
                default:
                begin
                    state_next = ST_IDLE;
                end
            endcase
        end
        // next read byte: data, crc8, then idle fill
        if (load)
        begin
            state_next = ST_TX;
            bit_cnt_next = 3'h0;
            tx_data_next = 1'b0;
            if (crc_mode_reg && cnt4 == len_plus)
            begin
                tx_shift_next = crc8_val;
            end
            else if (crc_mode_reg && cnt4 > len_plus)
            begin
                tx_shift_next = IDLE_BYTE;
            end
            else
            begin
                tx_shift_next = cur_addr_reg[0] ? mem_rdata[15:8] : mem_rdata[7:0];
                tx_data_next = 1'b1;
                cur_addr_next = cur_addr_reg + 8'h01;
            end
            if (data_cnt_reg != CNT_MAX)
            begin
                data_cnt_next = data_cnt_reg + 3'h1;
            end
            oe_n_next = tx_shift_next[7];
        end
        // idle memory port follows the read word
        if (!mem_we_next)
        begin
            mem_addr_next = {cur_addr_next[7:1], 1'b0};
        end
        // a fault in the clearing cycle still sticks
        fault_next = fault_set | (fault_reg & ~crc_fault_clr);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
            byte_idx_reg <= IDX_SLAVE;
            done_reg <= 1'b0;
            ack_reg <= 1'b0;
            rw_reg <= 1'b0;
            crc_mode_reg <= 1'b0;
            start_addr_reg <= 8'h00;
            cur_addr_reg <= 8'h00;
            len_reg <= 4'h0;
            data_cnt_reg <= 3'h0;
            wlo_reg <= 8'h00;
            wbuf_reg <= 32'h0000_0000;
            tx_shift_reg <= 8'h00;
            tx_data_reg <= 1'b0;
            mack_ok_reg <= 1'b0;
            commit_left_reg <= 2'h0;
            commit_idx_reg <= 1'b0;
            oe_n_reg <= 1'b1;
            mem_addr_reg <= 8'h00;
            mem_wdata_reg <= 16'h0000;
            mem_we_reg <= 1'b0;
            fault_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            byte_idx_reg <= byte_idx_next;
            done_reg <= done_next;
            ack_reg <= ack_next;
            rw_reg <= rw_next;
            crc_mode_reg <= crc_mode_next;
            start_addr_reg <= start_addr_next;
            cur_addr_reg <= cur_addr_next;
            len_reg <= len_next;
            data_cnt_reg <= data_cnt_next;
            wlo_reg <= wlo_next;
            wbuf_reg <= wbuf_next;
            tx_shift_reg <= tx_shift_next;
            tx_data_reg <= tx_data_next;
            mack_ok_reg <= mack_ok_next;
            commit_left_reg <= commit_left_next;
            commit_idx_reg <= commit_idx_next;
            oe_n_reg <= oe_n_next;
            mem_addr_reg <= mem_addr_next;
            mem_wdata_reg <= mem_wdata_next;
            mem_we_reg <= mem_we_next;
            fault_reg <= fault_next;
        end
    end

    // open drain: the driven level is always low, only the enable moves
    assign sda_out = 1'b0;
    assign sda_oe_n = oe_n_reg;
    assign mem_addr = mem_addr_reg;
    assign mem_wdata = mem_wdata_reg;
    assign mem_we = mem_we_reg;
    assign crc_fault = fault_reg;

endmodule
`default_nettype wire

// ===== sensor_register_i2c_slave_sva.sv
// port checker for the two-wire register slave
// assumes one clock domain; bound into every slave instance below
`timescale 1ns/1ns
`default_nettype none
module sensor_register_i2c_slave_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic [7:0] mem_addr,
    input wire logic mem_we,
    input wire logic crc_fault,
    input wire logic crc_fault_clr
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // open drain: the pin may only be pulled low
    a_pin_open_drain: assert property (sda_out == 1'b0)
        else $error("data pin drive value not low");
    a_write_even: assert property (mem_we |-> !mem_addr[0])
        else $error("memory write at odd address");
    a_write_next_word: assert property (
        mem_we && $past(mem_we) |-> mem_addr == $past(mem_addr) + 8'h02)
        else $error("back to back writes not consecutive");
    a_fault_sticky: assert property (crc_fault && !crc_fault_clr |=> crc_fault)
        else $error("crc fault dropped without clear");
    a_fault_no_write: assert property ($rose(crc_fault) |-> !mem_we)
        else $error("write alongside crc fault");
    // drive moves only with clock low, never faking start/stop
    a_drive_scl_low: assert property (!$stable(sda_oe_n) |-> !scl_in)
        else $error("data drive changed while clock high");
    a_stop_release: assert property (
        scl_in && $past(scl_in) && $rose(sda_in) |=> sda_oe_n [*2])
        else $error("data line held after stop");
    a_reset_idle: assert property ($past(rst) |-> sda_oe_n && !mem_we && !crc_fault)
        else $error("outputs not idle after reset");
endmodule
bind sensor_register_i2c_slave sensor_register_i2c_slave_sva i_sva (.clk(clk), .rst(rst),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .mem_addr(mem_addr), .mem_we(mem_we), .crc_fault(crc_fault), .crc_fault_clr(crc_fault_clr));
`default_nettype wire

// ===== i2c_master_model.sv
// bus master model: drives the clock, releases or pulls the data line
// assumes a 100 ns clk; clock low and high four cycles each
`timescale 1ns/1ns
`default_nettype none
module i2c_master_model (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_rel
);
    // clock stands high between frames
    initial
    begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // start (s=1) or stop (s=0)
    task automatic cond(input logic s);
        tick(1);
        sda_rel <= s;
        tick(4);
        scl <= 1'b1;
        tick(4);
        sda_rel <= !s;
        tick(4);
        scl <= !s;
    endtask
    // one bit each way, wire sampled mid high phase
    task automatic bitx(input logic b, output logic r);
        tick(1);
        sda_rel <= b;
        tick(3);
        scl <= 1'b1;
        tick(2);
        r = sda;
        tick(2);
        scl <= 1'b0;
    endtask
    // byte msb first, then ack slot
    task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
        output logic ack);
        for (int i = 7; i >= 0; i--)
            bitx(tx[i], rx[i]);
        bitx(ack_in, ack);
    endtask
endmodule
`default_nettype wire

// ===== sensor_register_i2c_slave_tb.sv
// bench: master model on the bus, word memory on the memory port
// assumes the checker binds itself; data from a fixed seed
`timescale 1ns/1ns
`default_nettype none
module sensor_register_i2c_slave_tb;
    import i2c_reg_pkg::*;
    logic clk, rst, scl, sda_rel, sda_out, sda_oe_n, mem_we, crc_fault, crc_fault_clr;
    logic [7:0] mem_addr, a, b;
    logic [15:0] mem_wdata;
    logic [15:0] mem [128];
    logic [15:0] ref_mem [128];
    logic [23:0] exp_q [$];
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    // pull-up on the data line
    wire logic sda = sda_rel & (sda_oe_n | sda_out);
    sensor_register_i2c_slave i_dut (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_we(mem_we), .mem_rdata(mem[mem_addr[7:1]]), .crc_fault(crc_fault),
        .crc_fault_clr(crc_fault_clr));
    i2c_master_model i_master (.clk(clk), .sda(sda), .scl(scl), .sda_rel(sda_rel));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input string s, input logic [23:0] e, input logic [23:0] g);
        cmp_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic logic [7:0] hdr(input logic p, input logic rw);
        return {DEV_ADDR_DEFAULT[6:1], p, rw};
    endfunction
    // bit serial crc, msb first; w8 picks the 8-bit code
    function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d, input int n,
        input logic w8);
        logic [7:0] poly;
        poly = w8 ? CRC8_POLY : {4'h0, CRC4_POLY};
        for (int i = 7; i > 7 - n; i--)
            c = (c << 1) ^ ((d[i] ^ (w8 ? c[7] : c[3])) ? poly : 8'h00);
        return w8 ? c : {4'h0, c[3:0]};
    endfunction
    function automatic logic [7:0] lenb(input logic [7:0] ad, input logic [3:0] code);
        logic [7:0] c;
        c = crc(crc({4'h0, CRC4_SEED}, hdr(1'b1, 1'b0), 8, 1'b0), ad, 8, 1'b0);
        c = crc(c, {code, 4'h0}, 4, 1'b0);
        return {code, c[3:0]};
    endfunction
    task automatic sb(input logic [7:0] d, input logic ea);
        logic [7:0] rx;
        logic ack;
        i_master.xfer(d, 1'b1, rx, ack);
        chk("slave ack", {23'h0, ea}, {23'h0, ack});
    endtask
    // n words from ad; good=0 spoils the crc8 byte of a crc frame
    task automatic wr(input logic [7:0] ad, input int n, input logic p, input logic good);
        logic [15:0] w;
        logic [7:0] c;
        c = CRC8_SEED;
        i_master.cond(1'b1);
        sb(hdr(p, 1'b0), 1'b0);
        sb(ad, 1'b0);
        if (p)
            sb(lenb(ad, 4'(2 * n - 1)), 1'b0);
        for (int i = 0; i < n; i++)
        begin
            w = 16'($urandom);
            c = crc(crc(c, w[7:0], 8, 1'b1), w[15:8], 8, 1'b1);
            if (good)
            begin
                exp_q.push_back({ad + 8'(2 * i), w});
                ref_mem[ad[7:1] + 7'(i)] = w;
            end
            sb(w[7:0], 1'b0);
            sb(w[15:8], 1'b0);
        end
        if (p)
            sb(c ^ {7'h0, !good}, !good);
        i_master.cond(1'b0);
    endtask
    // random read (set=1) or read-last of n bytes, crc8 last if p
    task automatic rd(input logic [7:0] ad, input int n, input logic p, input logic set);
        logic [7:0] rx, e, c;
        logic ack;
        c = CRC8_SEED;
        if (set)
        begin
            i_master.cond(1'b1);
            sb(hdr(p, 1'b0), 1'b0);
            sb(ad, 1'b0);
            if (p)
                sb(lenb(ad, 4'(n - 1)), 1'b0);
        end
        i_master.cond(1'b1);
        sb(hdr(p, 1'b1), 1'b0);
        for (int i = 0; i < n + p; i++)
        begin
            e = (i == n) ? c : ref_mem[ad[7:1] + 7'(i / 2)][8 * (i % 2) +: 8];
            c = crc(c, e, 8, 1'b1);
            i_master.xfer(8'hFF, i == n + p - 1, rx, ack);
            chk("read byte", {16'h0, e}, {16'h0, rx});
        end
        i_master.cond(1'b0);
    endtask
    // memory writes vs oldest note; hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            conclude();
        end
        if (mem_we === 1'b1)
        begin
            mem[mem_addr[7:1]] <= mem_wdata;
            chk("memory write", exp_q.size() ? exp_q.pop_front() : 24'hFFFFFF,
                {mem_addr, mem_wdata});
        end
    end
    initial
    begin
        rst = 1'b1;
        crc_fault_clr = 1'b0;
        void'($urandom(32'h1830F152));
        for (int i = 0; i < 128; i++)
        begin
            mem[i] = 16'($urandom);
            ref_mem[i] = mem[i];
        end
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        a = 8'($urandom) & 8'hF8;
        b = a ^ 8'h40;
        wr(a, 3, 1'b0, 1'b1);
        rd(a, 6, 1'b0, 1'b1);
        rd(a, 6, 1'b0, 1'b0);
        $display("test plain frames done");
        wr(b, 2, 1'b1, 1'b1);
        rd(b, 4, 1'b1, 1'b1);
        wr(b, 1, 1'b1, 1'b0);
        chk("crc fault set", 24'h1, {23'h0, crc_fault});
        crc_fault_clr <= 1'b1;
        @(posedge clk);
        crc_fault_clr <= 1'b0;
        @(posedge clk);
        chk("crc fault cleared", 24'h0, {23'h0, crc_fault});
        rd(a, 4, 1'b1, 1'b1);
        rd(a, 4, 1'b1, 1'b0);
        $display("test crc frames done");
        i_master.cond(1'b1);
        sb(hdr(1'b0, 1'b0) ^ 8'h08, 1'b1);
        i_master.cond(1'b0);
        chk("pending writes", 24'h0, 24'(exp_q.size()));
        $display("test foreign address done");
        conclude();
    end
endmodule
`default_nettype wire
